//--- rtl/rid_pkg.sv
// How it works
// (RULE_01) each instruction is one 14-bit word: class, opcode, operand fields
// (RULE_02) byte ops store to W when the destination bit is 0, else to the file
// (RULE_03) the file address field is seven bits, 0x00 through 0x7F
// (RULE_04) bit ops pick one bit of the addressed 8-bit register
// (RULE_05) literal ops use an 8-bit literal, jumps an 11-bit constant
// (RULE_06) don't-care encoding bits never change the decoded result
// (RULE_07) one cycle, two when a skip is taken or the PC changes; second is idle
// (RULE_08) one instruction cycle lasts exactly four clocks
// (RULE_09) flag updates override the value written into the status register
// (RULE_10) direction register bit 3 always reads one, pin is input only
// (RULE_11) writing PC low loads PC high from its latch and the result into PC low
// (RULE_12) bit set and clear read the whole byte and write it all back
// (RULE_13) byte ops: 00, four-bit op, destination bit, seven-bit address
// (RULE_14) bit ops: 01, two-bit op, three-bit position, seven-bit address
// (RULE_15) port read-modify-write takes the pin levels, not the output latch
package rid_pkg;
    localparam int IW = 14;
    localparam int PCW = 13;
    localparam int QUARTERS = 4;
    localparam logic [1:0] Q_FETCH = 2'h1;
    localparam logic [PCW-1:0] PC_RST = 13'h0000;
    localparam logic [PCW-1:0] PC_STEP = 13'h0001;
    localparam logic [6:0] ADR_PC_LOW = 7'h02;
    localparam logic [6:0] ADR_STATUS = 7'h03;
    localparam logic [6:0] ADR_DIR = 7'h05;
    localparam logic [6:0] ADR_PORT = 7'h06;
    localparam logic [6:0] ADR_PC_LATCH = 7'h0A;
    localparam int ST_C = 0;
    localparam int ST_HC = 1;
    localparam int ST_Z = 2;
    localparam int DIR_FIXED_BIT = 3;
    localparam logic [7:0] DIR_FIXED_MASK = 8'h08;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] DIR_RST = 8'hFF;
    localparam logic [7:0] W_RST = 8'h00;
    localparam logic [4:0] PC_LATCH_RST = 5'h00;
    localparam logic [1:0] CLS_BYTE = 2'h0;
    localparam logic [1:0] CLS_BIT = 2'h1;
    localparam logic [1:0] CLS_JUMP = 2'h2;
    localparam logic [1:0] CLS_LIT = 2'h3;
    localparam logic [3:0] OP_MOVWF = 4'h0;
    localparam logic [3:0] OP_CLR = 4'h1;
    localparam logic [3:0] OP_SUB = 4'h2;
    localparam logic [3:0] OP_DEC = 4'h3;
    localparam logic [3:0] OP_IOR = 4'h4;
    localparam logic [3:0] OP_AND = 4'h5;
    localparam logic [3:0] OP_XOR = 4'h6;
    localparam logic [3:0] OP_ADD = 4'h7;
    localparam logic [3:0] OP_MOV = 4'h8;
    localparam logic [3:0] OP_COM = 4'h9;
    localparam logic [3:0] OP_INC = 4'hA;
    localparam logic [3:0] OP_DECSZ = 4'hB;
    localparam logic [3:0] OP_RRF = 4'hC;
    localparam logic [3:0] OP_RLF = 4'hD;
    localparam logic [3:0] OP_SWAP = 4'hE;
    localparam logic [3:0] OP_INCSZ = 4'hF;
    localparam logic [7:0] LOW_RET = 8'h08;
    localparam logic [7:0] LOW_RETFIE = 8'h09;
    localparam logic [1:0] BOP_CLR = 2'h0;
    localparam logic [1:0] BOP_SET = 2'h1;
    localparam logic [1:0] BOP_TSTC = 2'h2;
    localparam logic [1:0] BOP_TSTS = 2'h3;
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_CORE = 12'h004;
    localparam logic [11:0] OFS_PC = 12'h008;
    localparam int CTRL_RUN = 0;
endpackage

//--- rtl/rid_phase.sv
`timescale 1ns/100ps
module rid_phase import rid_pkg::*; #(
    parameter int NQ = QUARTERS
) (
    input wire logic clk_in,
    input wire logic rst_in,
    output logic [$clog2(NQ)-1:0] phase_out,
    output logic last_out
);
    localparam int PW = $clog2(NQ);
    localparam logic [PW-1:0] Q_LAST = PW'(NQ - 1);
    logic [PW-1:0] q_q;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            q_q <= '0;
        end else begin
            q_q <= q_q + 1'b1; // [RULE_08]
        end
    end

    assign phase_out = q_q;
    assign last_out = (q_q == Q_LAST);
endmodule // rid_phase

//--- rtl/rid_alu.sv
`timescale 1ns/100ps
module rid_alu import rid_pkg::*; (
    input wire logic [3:0] op_in,
    input wire logic [7:0] f_in,
    input wire logic [7:0] w_in,
    input wire logic carry_in,
    output logic [7:0] res_out,
    output logic c_out,
    output logic hc_out,
    output logic z_out,
    output logic upd_c_out,
    output logic upd_hc_out,
    output logic upd_z_out
);
    wire sub = (op_in == OP_SUB);
    wire [7:0] wn = sub ? ~w_in : w_in;
    wire [8:0] sum = {1'b0, f_in} + {1'b0, wn} + {8'h00, sub};
    wire [4:0] nib = {1'b0, f_in[3:0]} + {1'b0, wn[3:0]} + {4'h0, sub};

    always_comb begin
        case (op_in)
            OP_MOVWF: res_out = w_in;
            OP_CLR: res_out = 8'h00;
            OP_SUB, OP_ADD: res_out = sum[7:0];
            OP_DEC, OP_DECSZ: res_out = f_in - 8'h01;
            OP_IOR: res_out = f_in | w_in;
            OP_AND: res_out = f_in & w_in;
            OP_XOR: res_out = f_in ^ w_in;
            OP_COM: res_out = ~f_in;
            OP_INC, OP_INCSZ: res_out = f_in + 8'h01;
            OP_RRF: res_out = {carry_in, f_in[7:1]};
            OP_RLF: res_out = {f_in[6:0], carry_in};
            OP_SWAP: res_out = {f_in[3:0], f_in[7:4]};
            default: res_out = f_in;
        endcase
    end

    assign c_out = (op_in == OP_RRF) ? f_in[0] : (op_in == OP_RLF) ? f_in[7] : sum[8];
    assign hc_out = nib[4];
    assign z_out = (res_out == 8'h00);
    assign upd_c_out = op_in inside {OP_ADD, OP_SUB, OP_RRF, OP_RLF};
    assign upd_hc_out = op_in inside {OP_ADD, OP_SUB};
    assign upd_z_out = op_in inside {OP_CLR, OP_SUB, OP_DEC, OP_IOR, OP_AND,
        OP_XOR, OP_ADD, OP_MOV, OP_COM, OP_INC};
endmodule // rid_alu

//--- rtl/rid_core.sv
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/100ps
module rid_core import rid_pkg::*; #(
    parameter int STK_DEPTH = 8,
    parameter int PORT_W = 6
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [11:0] paddr_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output logic [PCW-1:0] pm_addr_out,
    input wire logic [IW-1:0] pm_data_in,
    input wire logic [PORT_W-1:0] port_pins_in,
    output logic [PORT_W-1:0] port_latch_out,
    output logic [PORT_W-1:0] port_oe_out
);
    localparam int SPW = $clog2(STK_DEPTH);

    logic [1:0] phase;
    logic cyc_end;
    logic run_q;
    logic [IW-1:0] ir_q;
    logic [PCW-1:0] pc_q;
    logic [PCW-1:0] pc_d;
    logic [7:0] w_q;
    logic [7:0] status_q;
    logic [7:0] status_d;
    logic [7:0] dir_q;
    logic [4:0] pc_latch_q;
    logic [PORT_W-1:0] latch_q;
    logic [PORT_W-1:0] pins_m_q;
    logic [PORT_W-1:0] pins_s_q;
    logic nop_q;
    logic nop_adv_q;
    logic [7:0] ram_q [0:127];
    logic [PCW-1:0] stk_q [0:STK_DEPTH-1];
    logic [SPW-1:0] sp_q;
    logic [31:0] prdata_q;
    logic err_q;
    logic [7:0] alu_res;
    logic alu_c;
    logic alu_hc;
    logic alu_z;
    logic upd_c;
    logic upd_hc;
    logic upd_z;

    rid_phase #(.NQ(QUARTERS)) u_phase (
        .clk_in(core_clk_in),
        .rst_in(rst_in),
        .phase_out(phase),
        .last_out(cyc_end)
    );

    // pins cross into the core clock
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            pins_m_q <= '0;
            pins_s_q <= '0;
        end else begin
            pins_m_q <= port_pins_in;
            pins_s_q <= pins_m_q;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            ir_q <= '0;
        end else if (phase == Q_FETCH) begin
            ir_q <= pm_data_in;
        end
    end

    // field split
    wire [1:0] cls = ir_q[13:12]; // [RULE_01]
    wire [3:0] bop = ir_q[11:8]; // [RULE_13]
    wire dst_f = ir_q[7]; // [RULE_02]
    wire [6:0] fadr = ir_q[6:0]; // [RULE_03]
    wire [1:0] bitop = ir_q[11:10]; // [RULE_14]
    wire [2:0] bpos = ir_q[9:7]; // [RULE_04]
    wire [7:0] k8 = ir_q[7:0]; // [RULE_05]
    wire [10:0] k11 = ir_q[10:0]; // [RULE_05]

    wire is_byte = (cls == CLS_BYTE);
    wire is_bit = (cls == CLS_BIT);
    wire is_jump = (cls == CLS_JUMP);
    wire is_lit = (cls == CLS_LIT);
    wire is_call = is_jump && !ir_q[11];
    wire misc = is_byte && (bop == OP_MOVWF) && !dst_f;
    wire is_ret = misc && ((k8 == LOW_RET) || (k8 == LOW_RETFIE));
    // literal decode looks only at the bits that matter
    wire lit_mov = is_lit && !ir_q[11]; // [RULE_06]
    wire is_retlw = is_lit && (ir_q[11:10] == 2'b01); // [RULE_06]
    wire [3:0] lit_op = ir_q[10] ? (ir_q[9] ? OP_ADD : OP_SUB) // [RULE_06]
        : (ir_q[9:8] == 2'b00) ? OP_IOR : (ir_q[9:8] == 2'b01) ? OP_AND : OP_XOR;
    wire [3:0] alu_op = is_lit ? (lit_mov ? OP_MOV : lit_op) : bop;

    // source operand
    wire [7:0] dir_rd = dir_q | DIR_FIXED_MASK; // [RULE_10]
    wire [7:0] pins_rd = {{(8 - PORT_W){1'b0}}, pins_s_q};
    wire special = fadr inside {ADR_PC_LOW, ADR_STATUS, ADR_DIR, ADR_PORT, ADR_PC_LATCH};
    wire [7:0] rd_val = (fadr == ADR_PC_LOW) ? pc_q[7:0] // [RULE_11]
        : (fadr == ADR_STATUS) ? status_q
        : (fadr == ADR_PC_LATCH) ? {3'h0, pc_latch_q}
        : (fadr == ADR_PORT) ? pins_rd // [RULE_15]
        : (fadr == ADR_DIR) ? dir_rd
        : ram_q[fadr];

    rid_alu u_alu (
        .op_in(alu_op),
        .f_in(is_lit ? k8 : rd_val),
        .w_in(w_q),
        .carry_in(status_q[ST_C]),
        .res_out(alu_res),
        .c_out(alu_c),
        .hc_out(alu_hc),
        .z_out(alu_z),
        .upd_c_out(upd_c),
        .upd_hc_out(upd_hc),
        .upd_z_out(upd_z)
    );

    // bit set and clear rewrite the whole byte with one bit changed
    wire [7:0] mask = 8'h01 << bpos; // [RULE_04]
    wire bit_val = |(rd_val & mask);
    wire [7:0] bit_res = (bitop == BOP_SET) ? (rd_val | mask) : (rd_val & ~mask); // [RULE_12]
    wire [7:0] res = is_bit ? bit_res : lit_mov ? k8 : alu_res;

    wire exec = cyc_end && run_q && !nop_q;
    wire wr_f_nx = (is_byte && dst_f) || (is_bit && !bitop[1]); // [RULE_02]
    wire wr_file = exec && wr_f_nx;
    wire wr_w = exec && ((is_byte && !dst_f && !misc) || is_lit); // [RULE_02]
    wire wr_pc_low_nx = wr_f_nx && (fadr == ADR_PC_LOW);
    wire upd_flags = exec && (is_byte || (is_lit && !lit_mov));
    wire skip = (is_byte && (bop == OP_DECSZ || bop == OP_INCSZ) && alu_z)
        || (is_bit && bitop == BOP_TSTC && !bit_val)
        || (is_bit && bitop == BOP_TSTS && bit_val);
    wire pc_chg = is_jump || is_ret || is_retlw || wr_pc_low_nx;
    wire two_cyc = skip || pc_chg; // [RULE_07]
    wire [SPW-1:0] sp_up = sp_q + 1'b1;
    wire [SPW-1:0] sp_dn = sp_q - 1'b1;
    wire [PCW-1:0] pc_inc = pc_q + PC_STEP;

    always_comb begin
        pc_d = pc_inc;
        if (is_jump) begin
            pc_d = {pc_latch_q[4:3], k11}; // [RULE_05]
        end else if (is_ret || is_retlw) begin
            pc_d = stk_q[sp_dn];
        end else if (wr_pc_low_nx) begin
            pc_d = {pc_latch_q, res}; // [RULE_11]
        end
    end

    // flags from the instruction land on top of a written status byte
    always_comb begin
        status_d = status_q;
        if (wr_file && fadr == ADR_STATUS) begin
            status_d = res;
        end
        if (upd_flags && upd_c) begin
            status_d[ST_C] = alu_c; // [RULE_09]
        end
        if (upd_flags && upd_hc) begin
            status_d[ST_HC] = alu_hc; // [RULE_09]
        end
        if (upd_flags && upd_z) begin
            status_d[ST_Z] = alu_z; // [RULE_09]
        end
    end

    // one commit per four-clock cycle; second slot of a long op is idle
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            pc_q <= PC_RST;
            nop_q <= 1'b0;
            nop_adv_q <= 1'b0;
        end else if (cyc_end && run_q) begin // [RULE_08]
            if (nop_q) begin
                nop_q <= 1'b0;
                pc_q <= nop_adv_q ? pc_inc : pc_q; // [RULE_07]
            end else begin
                pc_q <= pc_d;
                nop_q <= two_cyc; // [RULE_07]
                nop_adv_q <= skip;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            w_q <= W_RST;
            status_q <= STATUS_RST;
            pc_latch_q <= PC_LATCH_RST;
            dir_q <= DIR_RST;
            latch_q <= '0;
            sp_q <= '0;
        end else begin
            status_q <= status_d;
            if (wr_w) begin
                w_q <= res; // [RULE_02]
            end
            if (wr_file && fadr == ADR_PC_LATCH) begin
                pc_latch_q <= res[4:0];
            end
            if (wr_file && fadr == ADR_DIR) begin
                dir_q <= res; // [RULE_10]
            end
            if (wr_file && fadr == ADR_PORT) begin
                latch_q <= res[PORT_W-1:0]; // [RULE_15]
            end
            if (exec && is_call) begin
                sp_q <= sp_up;
            end else if (exec && (is_ret || is_retlw)) begin
                sp_q <= sp_dn;
            end
        end
    end

    // data storage, no reset
    always_ff @(posedge core_clk_in) begin
        if (wr_file && !special) begin
            ram_q[fadr] <= res; // [RULE_02]
        end
        if (exec && is_call) begin
            stk_q[sp_q] <= pc_inc;
        end
    end

    // apb slave, zero wait, read data captured in setup
    wire apb_setup = psel_in && !penable_in;
    wire apb_acc = psel_in && penable_in;
    wire mapped = paddr_in inside {OFS_CTRL, OFS_CORE, OFS_PC};
    wire [31:0] rd_mux = (paddr_in == OFS_CTRL) ? {31'h0, run_q}
        : (paddr_in == OFS_CORE) ? {2'h0, ir_q, status_q, w_q}
        : (paddr_in == OFS_PC) ? {{(32 - PCW){1'b0}}, pc_q}
        : 32'h0000_0000;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            prdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
            run_q <= 1'b0;
        end else begin
            if (apb_setup) begin
                prdata_q <= pwrite_in ? 32'h0000_0000 : rd_mux;
                err_q <= !mapped;
            end
            if (apb_acc && pwrite_in && paddr_in == OFS_CTRL) begin
                run_q <= pwdata_in[CTRL_RUN];
            end
        end
    end

    assign prdata_out = prdata_q;
    assign pready_out = apb_acc;
    assign pslverr_out = apb_acc && err_q;
    assign pm_addr_out = pc_q;
    assign port_latch_out = latch_q;
    assign port_oe_out = ~dir_rd[PORT_W-1:0];

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    sequence s_rest;
        !cyc_end [*3] ##1 cyc_end;
    endsequence

    sequence s_nop_slot;
        nop_q [*4] ##1 !nop_q;
    endsequence

    a_cycle_four_clocks: assert property ( // [RULE_08]
        cyc_end |=> s_rest
    ) else $error("instruction cycle is not four clocks");

    a_dest_w_reg: assert property ( // [RULE_02]
        exec && is_byte && !dst_f && !misc |=> w_q == $past(res)
    ) else $error("byte op with destination zero missed W");

    a_dest_file_reg: assert property ( // [RULE_02]
        exec && is_byte && dst_f && !special
        |=> ram_q[$past(fadr)] == $past(res) && $stable(w_q)
    ) else $error("byte op with destination one missed the file");

    a_dir_bit_fixed: assert property ( // [RULE_10]
        dir_rd[DIR_FIXED_BIT] && !port_oe_out[DIR_FIXED_BIT]
    ) else $error("direction bit 3 not reading one");

    a_status_flag_wins: assert property ( // [RULE_09]
        wr_file && fadr == ADR_STATUS && upd_flags && upd_z
        |=> status_q[ST_Z] == $past(alu_z)
    ) else $error("zero flag did not override status write");

    a_pc_low_loads: assert property ( // [RULE_11]
        exec && wr_pc_low_nx |=> pc_q == {$past(pc_latch_q), $past(res)}
    ) else $error("PC low write did not load full PC");

    a_two_cycle_op: assert property ( // [RULE_07]
        exec && two_cyc |=> s_nop_slot
    ) else $error("long instruction did not idle one cycle");

    a_one_cycle_op: assert property ( // [RULE_07]
        exec && !two_cyc |=> !nop_q ##1 !nop_q [*3]
    ) else $error("short instruction took an idle slot");

    a_bit_rmw_byte: assert property ( // [RULE_12]
        exec && is_bit && !bitop[1]
        |-> ((res ^ rd_val) & ~mask) == 8'h00 && res[bpos] == bitop[0]
    ) else $error("bit op disturbed other bits");

    a_port_from_pins: assert property ( // [RULE_15]
        wr_file && fadr == ADR_PORT && is_byte && bop == OP_MOV
        |=> latch_q == $past(pins_s_q)
    ) else $error("port rewrite did not use pin levels");
endmodule // rid_core

//--- sim/rid_pmem_model.sv
`timescale 1ns/100ps
module rid_pmem_model import rid_pkg::*; (
    input wire logic clk_in,
    input wire logic [PCW-1:0] addr_in,
    output logic [IW-1:0] data_out
);
    logic [IW-1:0] mem [0:(1<<PCW)-1];
    // one clock of access time after the address moves
    always_ff @(posedge clk_in) begin
        data_out <= mem[addr_in];
    end
endmodule // rid_pmem_model

//--- sim/risc_instruction_decode_execute_tb.sv
`timescale 1ns/100ps
module risc_instruction_decode_execute_tb import rid_pkg::*; ;
    typedef struct {logic [31:0] exp; logic [31:0] mask; logic err;} rid_note_t;
    typedef struct {logic [PCW-1:0] adr; int len;} rid_span_t;
    logic core_clk_in, rst_in, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [PCW-1:0] pm_addr, last_adr;
    logic [IW-1:0] pm_data;
    logic [5:0] pins, latch, oe;
    rid_note_t notes[$];
    rid_span_t spans[$];
    rid_note_t nt;
    rid_span_t sp;
    int errors, checks_done, run_len;
    // movlw with don't-care bits set, bit ops on 0x7F, taken skip, status clear, self loop
    logic [IW-1:0] p1 [9] = '{14'h3355, 14'h00FF, 14'h14FF, 14'h107F, 14'h187F,
        14'h30FF, 14'h087F, 14'h0183, 14'h2808};
    // direction, port rmw, pc-high latch, pc-low write
    logic [IW-1:0] p2 [7] = '{14'h3000, 14'h0085, 14'h0886, 14'h3001, 14'h008A,
        14'h3009, 14'h0082};
    // call, literal return into W, literal add setting carry, half carry and zero
    logic [IW-1:0] p3 [6] = '{14'h300F, 14'h3E01, 14'h2005, 14'h3EC4, 14'h2804,
        14'h343C};

    rid_core DUT (.core_clk_in(core_clk_in), .rst_in(rst_in), .paddr_in(paddr),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .pm_addr_out(pm_addr), .pm_data_in(pm_data), .port_pins_in(pins),
        .port_latch_out(latch), .port_oe_out(oe));
    rid_pmem_model pmem (.clk_in(core_clk_in), .addr_in(pm_addr), .data_out(pm_data));

    initial begin
        core_clk_in = 1'b0;
        forever #25 core_clk_in = ~core_clk_in;
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge core_clk_in);
        penable <= 1'b1;
        k = 0;
        @(posedge core_clk_in);
        while (pready !== 1'b1 && k < 20) begin
            k++;
            @(posedge core_clk_in);
        end
        if (k >= 20) begin
            errors++;
            end_of_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk_in);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] mask,
        input logic err);
        notes.push_back('{exp, mask, err});
        apb(a, 1'b0, 32'h0000_0000);
    endtask

    task automatic run_prog(input logic [PCW-1:0] stop_adr);
        int k;
        rst_in <= 1'b1;
        repeat (4) @(posedge core_clk_in);
        rst_in <= 1'b0;
        @(posedge core_clk_in);
        apb(OFS_CTRL, 1'b1, 32'h0000_0001);
        k = 0;
        while (pm_addr !== stop_adr && k < 400) begin
            k++;
            @(posedge core_clk_in);
        end
        if (k >= 400) begin
            errors++;
            end_of_test();
        end
        repeat (12) @(posedge core_clk_in);
    endtask

    // read results against the oldest note, program-address spans against the oldest span
    always @(posedge core_clk_in) begin
        if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0) begin
            nt = notes.pop_front();
            check("prdata", nt.exp, prdata & nt.mask);
            check("pslverr", {31'h0, nt.err}, {31'h0, pslverr});
        end
        if (rst_in) begin
            last_adr = PC_RST;
            run_len = 0;
        end else if (pm_addr !== last_adr) begin
            if (last_adr !== PC_RST && spans.size() > 0) begin
                sp = spans.pop_front();
                check("span_adr", {19'h0, sp.adr}, {19'h0, last_adr});
                check("span_len", sp.len, run_len);
            end
            last_adr = pm_addr;
            run_len = 1;
        end else begin
            run_len++;
        end
    end

    initial begin
        rst_in = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        errors = 0;
        checks_done = 0;
        last_adr = PC_RST;
        run_len = 0;
        void'($urandom(32'h583B));
        pins = 6'h01 | 6'($urandom());
        for (int i = 0; i < (1 << PCW); i++) pmem.mem[i] = 14'h0000;
        foreach (p1[i]) pmem.mem[i] = p1[i];
        for (int i = 1; i < 8; i++) spans.push_back('{13'(i), 4});
        run_prog(13'h0008);
        apb(OFS_CORE, 1'b1, 32'hFFFF_FFFF);
        rd(OFS_CORE, 32'h2808_0456, 32'hFFFF_FFFF, 1'b0);
        rd(OFS_PC, 32'h0000_0008, 32'hFFFF_FFFF, 1'b0);
        rd(OFS_CTRL, 32'h0000_0001, 32'hFFFF_FFFF, 1'b0);
        rd(12'h00C, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1);
        rd(12'h001, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1);
        check("spans_left", 32'h0, spans.size());
        $display("test bit ops and skip done");
        for (int i = 0; i < (1 << PCW); i++) pmem.mem[i] = 14'h0000;
        foreach (p2[i]) pmem.mem[i] = p2[i];
        pmem.mem[13'h0109] = 14'h0805;
        pmem.mem[13'h010A] = 14'h290A;
        for (int i = 1; i < 7; i++) spans.push_back('{13'(i), 4});
        spans.push_back('{13'h0109, 8});
        pins <= 6'h01 | 6'($urandom());
        run_prog(13'h010A);
        rd(OFS_CORE, 32'h290A_0008, 32'hFFFF_FFFF, 1'b0);
        rd(OFS_PC, 32'h0000_010A, 32'hFFFF_FFFF, 1'b0);
        check("latch", {26'h0, pins}, {26'h0, latch});
        check("oe", 32'h0000_0037, {26'h0, oe});
        check("spans_left", 32'h0, spans.size());
        $display("test special registers done");
        for (int i = 0; i < (1 << PCW); i++) pmem.mem[i] = 14'h0000;
        foreach (p3[i]) pmem.mem[i] = p3[i];
        spans.push_back('{13'h0001, 4});
        spans.push_back('{13'h0002, 4});
        spans.push_back('{13'h0005, 8});
        spans.push_back('{13'h0003, 8});
        run_prog(13'h0004);
        rd(OFS_CORE, 32'h2804_0700, 32'hFFFF_FFFF, 1'b0);
        rd(OFS_PC, 32'h0000_0004, 32'hFFFF_FFFF, 1'b0);
        check("spans_left", 32'h0, spans.size());
        $display("test call and literal return done");
        end_of_test();
    end
endmodule // risc_instruction_decode_execute_tb
